// ---- csr_pkg.sv ----
/*
 * constants for the core special-function register block: data-memory
 * addresses, field positions, reset values and operation codes.
 * assumes the core's execute stage drives one data-memory access per cycle.
 */
package csr_pkg;

  // ************************************************************
  // data-memory addresses of the special registers
  // ************************************************************
  localparam logic [7:0] CSR_ADDR_IND0   = 8'h00;
  localparam logic [7:0] CSR_ADDR_PTR0   = 8'h01;
  localparam logic [7:0] CSR_ADDR_IND1   = 8'h02;
  localparam logic [7:0] CSR_ADDR_PTR1   = 8'h03;
  localparam logic [7:0] CSR_ADDR_BANK   = 8'h04;
  localparam logic [7:0] CSR_ADDR_WORK   = 8'h05;
  localparam logic [7:0] CSR_ADDR_PCL    = 8'h06;
  localparam logic [7:0] CSR_ADDR_TBLO   = 8'h07;
  localparam logic [7:0] CSR_ADDR_TBHL   = 8'h08;
  localparam logic [7:0] CSR_ADDR_FLAGS  = 8'h0A;
  localparam logic [7:0] CSR_ADDR_TBHI   = 8'h0C;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int         CSR_BIT_BANK    = 0;
  localparam int         CSR_BIT_CARRY   = 0;
  localparam int         CSR_BIT_NIBBLE  = 1;
  localparam int         CSR_BIT_NULL    = 2;
  localparam int         CSR_BIT_WRAP    = 3;
  localparam int         CSR_BIT_SLEEP   = 4;
  localparam int         CSR_BIT_WDOG    = 5;
  localparam logic [7:0] CSR_RST_BANK    = 8'h00;
  localparam logic [3:0] CSR_RST_ARITH   = 4'h0;
  localparam logic [7:0] CSR_RST_BYTE    = 8'h00;
  localparam int         CSR_PC_WIDTH    = 13;
  localparam int         CSR_DUMMY_CYC   = 1;

  // ************************************************************
  // alu operation codes and flag update selection
  // ************************************************************
  typedef enum logic [2:0] {
    CSR_OP_NONE  = 3'b000,
    CSR_OP_ADD   = 3'b001,
    CSR_OP_SUB   = 3'b010,
    CSR_OP_LOGIC = 3'b011,
    CSR_OP_RLC   = 3'b100,
    CSR_OP_RRC   = 3'b101
  } csr_op_t;

endpackage : csr_pkg

// ---- csr_core.sv ----
/*
 * core special-function registers: bank select, work register, pc low
 * write redirection, table pointers and latch, status flags.
 * assumes the execute stage presents one access per cycle on the same clock,
 * and that a watchdog reset raised from sleep holds i_wake_rst high with i_rst_b.
 */
`timescale 1ns/1ps
module csr_core
  import csr_pkg::*;
#(
  parameter int PC_W = CSR_PC_WIDTH
) (
  input  wire logic            i_mclk,        // system clock
  input  wire logic            i_rst_b,       // power-on reset, active low
  input  wire logic            i_wake_rst,    // watchdog reset in sleep
  input  wire logic            i_wr,          // data-memory write strobe
  input  wire logic            i_rd,          // data-memory read strobe
  input  wire logic [7:0]      i_addr,        // data-memory address
  input  wire logic [7:0]      i_wdata,       // write data
  input  wire logic            i_alu_valid,   // alu result strobe
  input  wire csr_op_t         i_alu_op,      // alu operation kind
  input  wire logic [7:0]      i_alu_a,       // operand a
  input  wire logic [7:0]      i_alu_b,       // operand b
  input  wire logic            i_alu_to_work, // result goes to work reg
  input  wire logic            i_tbl_rd,      // table read strobe
  input  wire logic [15:0]     i_tbl_word,    // fetched program word
  input  wire logic            i_wdt_expire,  // watchdog timed out
  input  wire logic            i_kick,        // dog_kick_instr executed
  input  wire logic            i_sleep,       // sleep instruction executed
  input  wire logic            i_pc_step,     // pc advance
  output logic      [7:0]      o_rdata,       // read data
  output logic      [7:0]      o_work,        // work_register
  output logic      [PC_W-1:0] o_pc,          // program counter
  output logic      [15:0]     o_tbl_addr,    // table read address
  output logic                 o_stall,       // dummy cycle insert
  output logic      [7:0]      o_bank_sel     // bank used by pointer one
);

  // ************************************************************
  // state
  // ************************************************************
  logic            bank_choice_bit_q;
  logic [7:0]      work_register_q;
  logic [PC_W-1:0] pc_q;
  logic [7:0]      table_ptr_low_q;
  logic [7:0]      table_ptr_high_q;
  logic [7:0]      table_high_latch_q;
  logic            watchdog_expiry_flag_q;
  logic            sleep_entered_flag_q;
  logic [3:0]      arith_q;
  logic            stall_q;
  logic [7:0]      rdata_q;

  // ************************************************************
  // decode
  // ************************************************************
  wire logic       wr_bank  = i_wr && (i_addr == CSR_ADDR_BANK);
  wire logic       wr_work  = i_wr && (i_addr == CSR_ADDR_WORK);
  wire logic       wr_pcl   = i_wr && (i_addr == CSR_ADDR_PCL);
  wire logic       wr_tblo  = i_wr && (i_addr == CSR_ADDR_TBLO);
  wire logic       wr_tbhi  = i_wr && (i_addr == CSR_ADDR_TBHI);
  wire logic       wr_tbhl  = i_wr && (i_addr == CSR_ADDR_TBHL);
  wire logic       wr_flags = i_wr && (i_addr == CSR_ADDR_FLAGS);

  // ************************************************************
  // alu flag evaluation
  // ************************************************************
  wire logic [8:0] sum9     = {1'b0, i_alu_a} + {1'b0, i_alu_b};
  wire logic [8:0] dif9     = {1'b0, i_alu_a} + {1'b0, ~i_alu_b} + 9'h001;
  wire logic [4:0] nsum     = {1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0]};
  wire logic [4:0] ndif     = {1'b0, i_alu_a[3:0]} + {1'b0, ~i_alu_b[3:0]} + 5'h01;
  wire logic [7:0] add_msb  = {1'b0, i_alu_a[6:0]} + {1'b0, i_alu_b[6:0]};
  wire logic [7:0] sub_msb  = {1'b0, i_alu_a[6:0]} + {1'b0, ~i_alu_b[6:0]} + 8'h01;
  wire logic       is_add   = (i_alu_op == CSR_OP_ADD);
  wire logic       is_sub   = (i_alu_op == CSR_OP_SUB);
  wire logic       is_arith = is_add || is_sub;
  wire logic       is_rot   = (i_alu_op == CSR_OP_RLC) || (i_alu_op == CSR_OP_RRC);
  wire logic [7:0] rot_res  = (i_alu_op == CSR_OP_RLC) ?
                              {i_alu_a[6:0], arith_q[CSR_BIT_CARRY]} :
                              {arith_q[CSR_BIT_CARRY], i_alu_a[7:1]};
  wire logic       rot_out  = (i_alu_op == CSR_OP_RLC) ? i_alu_a[7] : i_alu_a[0];
  wire logic [7:0] logic_res = i_alu_a & i_alu_b;
  // carry set on add carry-out, and on subtract with no borrow
  wire logic       cy_out   = is_add ? sum9[8] : dif9[8];
  wire logic       cy_in7   = is_add ? add_msb[7] : sub_msb[7];
  wire logic [7:0] res      = is_add ? sum9[7:0] :
                              is_sub ? dif9[7:0] :
                              is_rot ? rot_res : logic_res;
  wire logic       alu_go   = i_alu_valid && (i_alu_op != CSR_OP_NONE);

  logic [3:0] arith_d;
  always_comb begin
    arith_d = arith_q;
    if (wr_flags) begin
      arith_d = i_wdata[3:0];
    end
    if (alu_go) begin
      if (is_arith) begin
        arith_d[CSR_BIT_WRAP]   = cy_in7 ^ cy_out;
        arith_d[CSR_BIT_NIBBLE] = is_add ? nsum[4] : ndif[4];
        arith_d[CSR_BIT_CARRY]  = cy_out;
      end
      if (is_rot) begin
        arith_d[CSR_BIT_CARRY]  = rot_out;
      end else begin
        arith_d[CSR_BIT_NULL]   = (res == CSR_RST_BYTE);
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // a reset raised by the watchdog from sleep leaves the bank as it was
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      if (!i_wake_rst) begin
        bank_choice_bit_q <= CSR_RST_BANK[CSR_BIT_BANK];
      end
    end else if (wr_bank) begin
      bank_choice_bit_q <= i_wdata[CSR_BIT_BANK];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      work_register_q <= CSR_RST_BYTE;
    end else if (alu_go && i_alu_to_work) begin
      work_register_q <= res;
    end else if (wr_work) begin
      work_register_q <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pc_q    <= '0;
      stall_q <= 1'b0;
    end else if (wr_pcl) begin
      pc_q    <= {pc_q[PC_W-1:8], i_wdata};
      stall_q <= 1'b1;
    end else begin
      stall_q <= 1'b0;
      if (i_pc_step && !stall_q) begin
        pc_q <= pc_q + PC_W'(1);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      table_ptr_low_q    <= CSR_RST_BYTE;
      table_ptr_high_q   <= CSR_RST_BYTE;
      table_high_latch_q <= CSR_RST_BYTE;
    end else begin
      if (wr_tblo) begin
        table_ptr_low_q <= i_wdata;
      end
      if (wr_tbhi) begin
        table_ptr_high_q <= i_wdata;
      end
      if (i_tbl_rd) begin
        table_high_latch_q <= i_tbl_word[15:8];
      end else if (wr_tbhl) begin
        table_high_latch_q <= i_wdata;
      end
    end
  end

  // power-up clears both system flags; set wins over clear for timeout
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      watchdog_expiry_flag_q <= 1'b0;
      sleep_entered_flag_q   <= 1'b0;
      arith_q                <= CSR_RST_ARITH;
    end else begin
      if (i_wdt_expire) begin
        watchdog_expiry_flag_q <= 1'b1;
      end else if (i_kick || i_sleep) begin
        watchdog_expiry_flag_q <= 1'b0;
      end
      if (i_sleep) begin
        sleep_entered_flag_q <= 1'b1;
      end else if (i_kick) begin
        sleep_entered_flag_q <= 1'b0;
      end
      arith_q <= arith_d;
    end
  end

  // ************************************************************
  // read-back
  // ************************************************************
  // no stack path exists for the flags; calls leave them alone
  logic [7:0] rd_mux;
  always_comb begin
    case (i_addr)
      CSR_ADDR_BANK:  rd_mux = {7'h00, bank_choice_bit_q};
      CSR_ADDR_WORK:  rd_mux = work_register_q;
      CSR_ADDR_PCL:   rd_mux = pc_q[7:0];
      CSR_ADDR_TBLO:  rd_mux = table_ptr_low_q;
      CSR_ADDR_TBHI:  rd_mux = table_ptr_high_q;
      CSR_ADDR_TBHL:  rd_mux = table_high_latch_q;
      CSR_ADDR_FLAGS: rd_mux = {2'b00, watchdog_expiry_flag_q,
                                sleep_entered_flag_q, arith_q};
      default:        rd_mux = CSR_RST_BYTE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rdata_q <= CSR_RST_BYTE;
    end else if (i_rd) begin
      rdata_q <= rd_mux;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign o_rdata    = rdata_q;
  assign o_work     = work_register_q;
  assign o_pc       = pc_q;
  assign o_tbl_addr = {table_ptr_high_q, table_ptr_low_q};
  assign o_stall    = stall_q;
  // direct and pointer-zero accesses always use bank 0
  assign o_bank_sel = {7'h00, bank_choice_bit_q};

endmodule : csr_core

// ---- csr_core_monitor.sv ----
/* checker for csr_core port timing.
   assumes one clock domain and the bus usage of the execute model. */
`timescale 1ns/1ps
module csr_core_monitor
  import csr_pkg::*;
#(
  parameter int PC_W = CSR_PC_WIDTH
) (
  input wire logic            i_mclk,     // clock
  input wire logic            i_rst_b,    // reset, active low
  input wire logic            i_wake_rst, // sleep watchdog reset
  input wire logic            i_wr,       // write strobe
  input wire logic            i_rd,       // read strobe
  input wire logic [7:0]      i_addr,     // address
  input wire logic [7:0]      i_wdata,    // write data
  input wire logic            i_pc_step,  // pc advance
  input wire logic [7:0]      o_rdata,    // read data
  input wire logic [PC_W-1:0] o_pc,       // program counter
  input wire logic [15:0]     o_tbl_addr, // table address
  input wire logic            o_stall,    // dummy cycle
  input wire logic [7:0]      o_bank_sel  // bank select
);
  // ********************
  // properties
  // ********************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  sequence s_pcl_wr;
    i_wr && i_addr == CSR_ADDR_PCL && !i_pc_step;
  endsequence
  sequence s_one_dummy;
    o_stall ##1 !o_stall;
  endsequence
  chk_bank_upper_zero: assert property (o_bank_sel[7:1] == 7'h00)
    else $error("bank select upper bits set");
  chk_pcl_jump_low: assert property (s_pcl_wr |=> o_pc[7:0] == $past(i_wdata))
    else $error("pc low not loaded");
  chk_pcl_page_kept: assert property (s_pcl_wr |=> $stable(o_pc[PC_W-1:8]))
    else $error("pc page changed");
  chk_pcl_dummy_cycle: assert property (s_pcl_wr |=> s_one_dummy)
    else $error("dummy cycle wrong");
  chk_stall_pc_frozen: assert property (o_stall && !i_wr |=> $stable(o_pc))
    else $error("pc moved in dummy cycle");
  chk_tbl_low_write: assert property (i_wr && i_addr == CSR_ADDR_TBLO
    |=> o_tbl_addr[7:0] == $past(i_wdata))
    else $error("table low pointer wrong");
  chk_tbl_high_write: assert property (i_wr && i_addr == CSR_ADDR_TBHI
    |=> o_tbl_addr[15:8] == $past(i_wdata))
    else $error("table high pointer wrong");
  chk_flags_top_zero: assert property (i_rd && i_addr == CSR_ADDR_FLAGS
    |=> o_rdata[7:6] == 2'h0)
    else $error("status top bits set");
  chk_bank_wake_hold: assert property (i_wake_rst && !i_wr |=> $stable(o_bank_sel))
    else $error("bank changed on wake reset");
  chk_bank_reset_zero: assert property (disable iff (1'b0)
    !i_rst_b && !i_wake_rst |=> o_bank_sel == 8'h00)
    else $error("bank not cleared by reset");
  chk_wake_reset_hold: assert property (disable iff (1'b0)
    !i_rst_b && i_wake_rst |=> $stable(o_bank_sel))
    else $error("bank changed by watchdog reset");
endmodule : csr_core_monitor

bind csr_core csr_core_monitor #(.PC_W(PC_W)) u_mon (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
  .i_wake_rst(i_wake_rst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_pc_step(i_pc_step), .o_rdata(o_rdata), .o_pc(o_pc), .o_tbl_addr(o_tbl_addr),
  .o_stall(o_stall), .o_bank_sel(o_bank_sel));

// ---- csr_exec_model.sv ----
/* execute-stage model: data-memory and alu requests into the block.
   assumes the bench calls its tasks; drives at the falling edge. */
`timescale 1ns/1ps
module csr_exec_model
  import csr_pkg::*;
(
  input  wire logic       i_mclk,  // clock
  input  wire logic [7:0] i_rdata, // read data
  output logic            o_wr,    // write strobe
  output logic            o_rd,    // read strobe
  output logic      [7:0] o_addr,  // address
  output logic      [7:0] o_wdata, // write data
  output logic            o_alu_v, // alu strobe
  output csr_op_t         o_op,    // alu op
  output logic      [7:0] o_a,     // operand a
  output logic      [7:0] o_b,     // operand b
  output logic            o_to_w   // result to work
);
  initial begin
    {o_wr, o_rd, o_alu_v, o_to_w} = 4'h0;
    {o_addr, o_wdata, o_a, o_b} = 32'h0000_0000;
    o_op = CSR_OP_NONE;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    {o_wr, o_addr, o_wdata} = {1'b1, a, d};
    @(negedge i_mclk);
    // released bus shows the inverse so stale data cannot pass
    {o_wr, o_wdata} = {1'b0, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    {o_rd, o_addr} = {1'b1, a};
    @(negedge i_mclk);
    o_rd = 1'b0;
    d = i_rdata;
  endtask : rd
  // every alu result lands in the work register, never reg to reg
  task automatic alu(input csr_op_t op, input logic [7:0] a, input logic [7:0] b);
    @(negedge i_mclk);
    {o_alu_v, o_to_w, o_a, o_b} = {2'b11, a, b};
    o_op = op;
    @(negedge i_mclk);
    {o_alu_v, o_to_w, o_a, o_b} = {2'b00, ~a, ~b};
  endtask : alu
endmodule : csr_exec_model

// ---- csr_core_tb.sv ----
/* self-checking bench for csr_core.
   assumes the execute model and the bound checker. */
`timescale 1ns/1ps
module csr_core_tb;
  import csr_pkg::*;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [4:0] ev = 5'h00;
  logic i_pc_step = 1'b0;
  logic [15:0] tw = 16'h0000;
  logic wr, rd, av, tow;
  logic [7:0] addr, wd, a, b, rdata, work, bank, d;
  csr_op_t op;
  logic [12:0] pc;
  logic [15:0] taddr;
  logic stall;
  int compares = 0;
  int miscompares = 0;
  logic [16:0] cases [5] = '{17'h0_8080, 17'h0_0F01, 17'h1_0505, 17'h1_0001, 17'h0_7F01};
  always #5 i_mclk = ~i_mclk;
  csr_exec_model u_exec (.i_mclk(i_mclk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
    .o_addr(addr), .o_wdata(wd), .o_alu_v(av), .o_op(op), .o_a(a), .o_b(b), .o_to_w(tow));
  csr_core dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_wake_rst(ev[0]), .i_wr(wr),
    .i_rd(rd), .i_addr(addr), .i_wdata(wd), .i_alu_valid(av), .i_alu_op(op), .i_alu_a(a),
    .i_alu_b(b), .i_alu_to_work(tow), .i_tbl_rd(ev[4]), .i_tbl_word(tw),
    .i_wdt_expire(ev[1]), .i_kick(ev[2]), .i_sleep(ev[3]), .i_pc_step(i_pc_step),
    .o_rdata(rdata), .o_work(work), .o_pc(pc), .o_tbl_addr(taddr), .o_stall(stall),
    .o_bank_sel(bank));
  // ********************
  // helpers
  // ********************
  task automatic pulse(input int k);
    @(negedge i_mclk);
    ev[k] = 1'b1;
    @(negedge i_mclk);
    ev = 5'h00;
  endtask : pulse
  // expected {wrap, null, nibble, carry}; subtraction carries mean no borrow
  function automatic logic [3:0] exp_fl(input logic s, input logic [7:0] x, input logic [7:0] y);
    logic [8:0] r;
    logic h;
    r = s ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    h = s ? (x[3:0] >= y[3:0]) : (({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0F);
    return {((x[7] ^ y[7]) == s) && (r[7] != x[7]), r[7:0] == 8'h00, h, r[8] ^ s};
  endfunction : exp_fl
  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #50_000;
    miscompares++;
    report_and_stop();
  end
  // ********************
  // tests
  // ********************
  initial begin
    repeat (20) @(negedge i_mclk);
    i_rst_b = 1'b1;
    u_exec.rd(CSR_ADDR_BANK, d);
    `CHK(d, 8'h00)
    u_exec.rd(CSR_ADDR_FLAGS, d);
    `CHK(d, 8'h00)
    u_exec.wr(CSR_ADDR_BANK, 8'hFF);
    u_exec.rd(CSR_ADDR_BANK, d);
    `CHK(d, 8'h01)
    pulse(0);
    `CHK(bank, 8'h01)
    u_exec.rd(8'h09, d);
    `CHK(d, 8'h00)
    $display("test bank done");
    u_exec.wr(CSR_ADDR_FLAGS, 8'hFF);
    u_exec.rd(CSR_ADDR_FLAGS, d);
    `CHK(d, 8'h0F)
    u_exec.wr(CSR_ADDR_FLAGS, 8'h00);
    pulse(3);
    u_exec.rd(CSR_ADDR_FLAGS, d);
    `CHK(d, 8'h10)
    pulse(1);
    u_exec.rd(CSR_ADDR_FLAGS, d);
    `CHK(d, 8'h30)
    pulse(2);
    u_exec.rd(CSR_ADDR_FLAGS, d);
    `CHK(d, 8'h00)
    pulse(1);
    pulse(3);
    u_exec.wr(CSR_ADDR_FLAGS, 8'hFF);
    u_exec.rd(CSR_ADDR_FLAGS, d);
    `CHK(d, 8'h1F)
    $display("test flags done");
    foreach (cases[i]) begin
      u_exec.alu(cases[i][16] ? CSR_OP_SUB : CSR_OP_ADD, cases[i][15:8], cases[i][7:0]);
      u_exec.rd(CSR_ADDR_FLAGS, d);
      `CHK(d[3:0], exp_fl(cases[i][16], cases[i][15:8], cases[i][7:0]))
      `CHK(work, cases[i][16] ? cases[i][15:8] - cases[i][7:0] : cases[i][15:8] + cases[i][7:0])
    end
    u_exec.alu(CSR_OP_LOGIC, 8'hF0, 8'h0F);
    u_exec.rd(CSR_ADDR_FLAGS, d);
    `CHK(d[3:0], 4'hE)
    `CHK(work, 8'h00)
    u_exec.alu(CSR_OP_RLC, 8'h81, 8'h00);
    u_exec.rd(CSR_ADDR_FLAGS, d);
    `CHK(d[3:0], 4'hF)
    `CHK(work, 8'h02)
    u_exec.alu(CSR_OP_RRC, 8'h02, 8'h00);
    u_exec.rd(CSR_ADDR_FLAGS, d);
    `CHK(d[3:0], 4'hE)
    `CHK(work, 8'h81)
    $display("test alu done");
    u_exec.wr(CSR_ADDR_TBHI, 8'h12);
    u_exec.wr(CSR_ADDR_TBLO, 8'h34);
    `CHK(taddr, 16'h1234)
    tw = 16'hABCD;
    pulse(4);
    u_exec.rd(CSR_ADDR_TBHL, d);
    `CHK(d, 8'hAB)
    $display("test table done");
    @(negedge i_mclk);
    i_pc_step = 1'b1;
    repeat (256) @(negedge i_mclk);
    i_pc_step = 1'b0;
    `CHK(pc, 13'h0100)
    u_exec.wr(CSR_ADDR_PCL, 8'h55);
    `CHK(stall, 1'b1)
    i_pc_step = 1'b1;
    @(negedge i_mclk);
    i_pc_step = 1'b0;
    `CHK(pc, 13'h0155)
    `CHK(stall, 1'b0)
    $display("test pc done");
    @(negedge i_mclk);
    {i_rst_b, ev[0]} = 2'b01;
    @(negedge i_mclk);
    {i_rst_b, ev[0]} = 2'b10;
    `CHK(bank, 8'h01)
    `CHK(work, 8'h00)
    `CHK(pc, 13'h0000)
    @(negedge i_mclk);
    i_rst_b = 1'b0;
    @(negedge i_mclk);
    i_rst_b = 1'b1;
    `CHK(bank, 8'h00)
    u_exec.rd(CSR_ADDR_FLAGS, d);
    `CHK(d, 8'h00)
    $display("test reset done");
    report_and_stop();
  end
endmodule : csr_core_tb
